//--- hw/eau_pkg.sv
// constants and types shared by the effective address unit and its register file
// assumes a 16-bit address space and 8 general registers of 16 bits
package eau_pkg;

  localparam int ADDR_W = 16;
  localparam int NUM_REGS = 8;

  // addressing modes, one-hot
  typedef enum logic [9:0] {
    MD_REG     = 10'h001,
    MD_IND     = 10'h002,
    MD_DISP    = 10'h004,
    MD_POSTINC = 10'h008,
    MD_PREDEC  = 10'h010,
    MD_ABS8    = 10'h020,
    MD_ABS16   = 10'h040,
    MD_IMM     = 10'h080,
    MD_PCREL   = 10'h100,
    MD_MEMIND  = 10'h200
  } eau_mode_t;

  // instruction classes as seen by the address unit
  typedef enum logic [3:0] {
    CL_MOVE       = 4'h0,
    CL_ARITH      = 4'h1,
    CL_ARITH_IMM  = 4'h2,
    CL_WORD_ARITH = 4'h3,
    CL_ADDR_ADJ   = 4'h4,
    CL_MULDIV     = 4'h5,
    CL_BIT        = 4'h6,
    CL_BIT_REG    = 4'h7,
    CL_BRANCH     = 4'h8,
    CL_JUMP       = 4'h9,
    CL_FLAG_PUSH  = 4'ha,
    CL_FLAG_POP   = 4'hb
  } eau_cls_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUS  = 2'b10
  } eau_state_t;

  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [7:0] ABS8_PAGE = 8'hff;
  localparam logic [7:0] MEMIND_PAGE = 8'h00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] EVEN_MASK = 16'hfffe;
  localparam int BITNUM_LSB = 4;
  localparam int FLAG_HI_LSB = 8;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : eau_pkg

//--- hw/eau_gpr.sv
// general register file: eight 16-bit registers, byte halves addressable
// assumes one write per cycle; select bit 3 picks the lower half for bytes
`timescale 1ns/10ps
module eau_gpr #(
  parameter int NREG = eau_pkg::NUM_REGS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] rd_sel,
  output logic [15:0] rd_word,
  output logic [7:0] rd_byte,
  input wire logic [3:0] rd2_sel,
  output logic [15:0] rd2_word,
  output logic [7:0] rd2_byte,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic wr_word,
  input wire logic [15:0] wr_data
);

  logic [15:0] regs_q [NREG];

  // upper or lower half of a word by select bit 3
  function automatic logic [7:0] half_of(input logic [15:0] w, input logic lo);
    half_of = lo ? w[7:0] : w[15:8];
  endfunction : half_of

  assign rd_word = regs_q[rd_sel[2:0]];
  assign rd_byte = half_of(regs_q[rd_sel[2:0]], rd_sel[3]);
  assign rd2_word = regs_q[rd2_sel[2:0]];
  assign rd2_byte = half_of(regs_q[rd2_sel[2:0]], rd2_sel[3]);

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[gi] <= eau_pkg::RST_WORD;
        end else if (wr_en && wr_sel[2:0] == 3'(gi)) begin
          if (wr_word) begin
            regs_q[gi] <= wr_data;
          end else if (wr_sel[3]) begin
            regs_q[gi][7:0] <= wr_data[7:0];
          end else begin
            regs_q[gi][15:8] <= wr_data[7:0];
          end
        end
      end
    end
  endgenerate

endmodule : eau_gpr

//--- hw/eau_unit.sv
// effective address unit: operand, address and branch target generation
// assumes the decoder holds a request stable while req_valid and not req_ready
//
// Overview of operation
// - word data accesses and fetches clear address bit 0.
// - flag push writes two copies of the flag byte; pop keeps the upper byte.
// - ten addressing modes; each class accepts only its permitted modes.
// - register direct picks a byte half or whole word by instruction class.
// - register indirect uses the 16-bit register as the operand address.
// - displacement mode address_add bytes 3 and 4 to the register, moves only.
// - post-increment uses the register, then address_add 1 or 2 to it.
// - pre-decrement subtracts 1 or 2 first, uses and keeps the result.
// - 8-bit absolute places all-ones in the upper byte; byte moves and bits.
// - 16-bit absolute only for byte moves, word moves and jumps.
// - 8-bit immediate from byte 2, 16-bit from bytes 3 and 4, word moves.
// - address adjust implies 1 or 2; bit number is a 3-bit field.
// - branches add the sign-extended byte 2 displacement to the program counter.
// - memory indirect reads the word at zero-page byte 2 as the target.
// - odd branch targets are taken as the preceding even address.
// - arithmetic uses register direct; some byte operations also take immediates.
// - data transfers take every mode but program-relative, memory indirect and word 8-bit absolute.
// - bit operations use register, indirect or 8-bit absolute; bit number immediate or register.
// - registers are byte-addressable as data, whole words as addresses.
`timescale 1ns/10ps
module eau_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire eau_pkg::eau_cls_t req_cls,
  input wire eau_pkg::eau_mode_t req_mode,
  input wire logic req_word,
  input wire logic [3:0] req_reg_sel,
  input wire logic req_bit_from_reg,
  input wire logic [3:0] req_bit_reg_sel,
  input wire logic req_bit_in_b4,
  input wire logic [7:0] ins_byte2,
  input wire logic [7:0] ins_byte3,
  input wire logic [7:0] ins_byte4,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  output logic done_q,
  output logic illegal_q,
  output logic [15:0] ea_q,
  output logic [15:0] operand_q,
  output logic [15:0] target_q,
  output logic [2:0] bit_num_q,
  output logic [7:0] flags_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [15:0] mem_addr_q,
  output logic [15:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic ext_wr_en,
  output logic ext_wr_ready,
  input wire logic [3:0] ext_wr_sel,
  input wire logic ext_wr_word,
  input wire logic [15:0] ext_wr_data
);

  eau_pkg::eau_state_t state_q;
  logic accept;
  logic legal;
  logic op_word;
  logic [15:0] reg_w;
  logic [7:0] reg_b;
  logic [15:0] rd2_w;
  logic [7:0] rd2_b;
  logic [15:0] step;
  logic [15:0] ea_raw;
  logic [15:0] operand_d;
  logic [15:0] target_d;
  logic [2:0] bit_num_d;
  logic need_bus;
  logic bus_we;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  logic uw_en;
  logic [3:0] uw_sel;
  logic [15:0] uw_data;
  logic pop_ack;
  logic [15:0] pop_sp_q;
  logic pop_q;
  logic [3:0] rd2_sel;
  logic gw_en;
  logic [3:0] gw_sel;
  logic gw_word;
  logic [15:0] gw_data;

  // permitted modes per instruction class
  function automatic logic mode_ok(input eau_pkg::eau_cls_t c, input eau_pkg::eau_mode_t m,
                                   input logic w);
    mode_ok = 1'b0;
    case (c)
      eau_pkg::CL_MOVE: mode_ok = (m != eau_pkg::MD_PCREL) && (m != eau_pkg::MD_MEMIND)
                                  && !(m == eau_pkg::MD_ABS8 && w);
      eau_pkg::CL_ARITH, eau_pkg::CL_WORD_ARITH, eau_pkg::CL_ADDR_ADJ,
      eau_pkg::CL_MULDIV: mode_ok = (m == eau_pkg::MD_REG);
      eau_pkg::CL_ARITH_IMM: mode_ok = (m == eau_pkg::MD_REG)
                                       || (m == eau_pkg::MD_IMM && !w);
      eau_pkg::CL_BIT, eau_pkg::CL_BIT_REG: mode_ok = (m == eau_pkg::MD_REG)
          || (m == eau_pkg::MD_IND) || (m == eau_pkg::MD_ABS8);
      eau_pkg::CL_BRANCH: mode_ok = (m == eau_pkg::MD_PCREL);
      eau_pkg::CL_JUMP: mode_ok = (m == eau_pkg::MD_IND) || (m == eau_pkg::MD_ABS16)
                                  || (m == eau_pkg::MD_MEMIND);
      eau_pkg::CL_FLAG_PUSH, eau_pkg::CL_FLAG_POP: mode_ok = 1'b1;
      default: mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  assign req_ready = (state_q == eau_pkg::ST_IDLE);
  assign accept = req_valid && req_ready;
  assign legal = mode_ok(req_cls, req_mode, req_word)
                 && !(req_bit_from_reg && req_cls != eau_pkg::CL_BIT_REG);
  assign op_word = (req_cls == eau_pkg::CL_MOVE && req_word)
                   || req_cls == eau_pkg::CL_WORD_ARITH || req_cls == eau_pkg::CL_ADDR_ADJ
                   || req_cls == eau_pkg::CL_MULDIV;
  assign step = req_word ? eau_pkg::STEP_WORD : eau_pkg::STEP_BYTE;
  assign rd2_sel = req_bit_from_reg ? req_bit_reg_sel : {1'b0, eau_pkg::SP_IDX};

  eau_gpr u_gpr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rd_sel(req_reg_sel),
    .rd_word(reg_w),
    .rd_byte(reg_b),
    .rd2_sel(rd2_sel),
    .rd2_word(rd2_w),
    .rd2_byte(rd2_b),
    .wr_en(gw_en),
    .wr_sel(gw_sel),
    .wr_word(gw_word),
    .wr_data(gw_data)
  );

  // address, operand and target formation in the accept cycle
  always_comb begin
    ea_raw = eau_pkg::RST_WORD;
    operand_d = eau_pkg::RST_WORD;
    target_d = eau_pkg::RST_WORD;
    need_bus = 1'b0;
    bus_we = 1'b0;
    bus_addr = eau_pkg::RST_WORD;
    bus_wdata = eau_pkg::RST_WORD;
    uw_en = 1'b0;
    uw_sel = {1'b0, req_reg_sel[2:0]};
    uw_data = eau_pkg::RST_WORD;
    if (req_cls == eau_pkg::CL_FLAG_PUSH) begin
      ea_raw = (rd2_w - eau_pkg::STEP_WORD) & eau_pkg::EVEN_MASK;
      need_bus = 1'b1;
      bus_we = 1'b1;
      bus_addr = ea_raw;
      bus_wdata = {flags_in, flags_in};
      uw_en = 1'b1;
      uw_sel = {1'b0, eau_pkg::SP_IDX};
      uw_data = rd2_w - eau_pkg::STEP_WORD;
    end else if (req_cls == eau_pkg::CL_FLAG_POP) begin
      ea_raw = rd2_w & eau_pkg::EVEN_MASK;
      need_bus = 1'b1;
      bus_addr = ea_raw;
    end else begin
      unique case (req_mode)
        eau_pkg::MD_REG: operand_d = op_word ? reg_w : {eau_pkg::RST_BYTE, reg_b};
        eau_pkg::MD_IND: ea_raw = reg_w;
        eau_pkg::MD_DISP: ea_raw = reg_w + {ins_byte3, ins_byte4};
        eau_pkg::MD_POSTINC: begin
          ea_raw = reg_w;
          uw_en = 1'b1;
          uw_data = reg_w + step;
        end
        eau_pkg::MD_PREDEC: begin
          ea_raw = reg_w - step;
          uw_en = 1'b1;
          uw_data = reg_w - step;
        end
        eau_pkg::MD_ABS8: ea_raw = {eau_pkg::ABS8_PAGE, ins_byte2};
        eau_pkg::MD_ABS16: ea_raw = {ins_byte3, ins_byte4};
        eau_pkg::MD_IMM: operand_d = req_word ? {ins_byte3, ins_byte4}
                                              : {eau_pkg::RST_BYTE, ins_byte2};
        eau_pkg::MD_PCREL: target_d = (pc_in + {{8{ins_byte2[7]}}, ins_byte2})
                                      & eau_pkg::EVEN_MASK;
        eau_pkg::MD_MEMIND: begin
          need_bus = 1'b1;
          bus_addr = {eau_pkg::MEMIND_PAGE, ins_byte2} & eau_pkg::EVEN_MASK;
          ea_raw = bus_addr;
        end
      endcase
      if (req_cls == eau_pkg::CL_ADDR_ADJ) begin
        operand_d = step;
      end
      if (req_cls == eau_pkg::CL_JUMP && req_mode != eau_pkg::MD_MEMIND) begin
        target_d = ea_raw & eau_pkg::EVEN_MASK;
      end
      if (req_word) begin
        ea_raw = ea_raw & eau_pkg::EVEN_MASK;
      end
    end
  end

  assign bit_num_d = req_bit_from_reg ? rd2_b[2:0]
                     : (req_bit_in_b4 ? ins_byte4[eau_pkg::BITNUM_LSB +: 3]
                                      : ins_byte2[eau_pkg::BITNUM_LSB +: 3]);

  // register writes: unit updates win, external port waits
  assign pop_ack = (state_q == eau_pkg::ST_BUS) && mem_ack && pop_q;
  assign ext_wr_ready = !(accept && legal && uw_en) && !pop_ack;
  always_comb begin
    gw_en = ext_wr_en;
    gw_sel = ext_wr_sel;
    gw_word = ext_wr_word;
    gw_data = ext_wr_data;
    if (pop_ack) begin
      gw_en = 1'b1;
      gw_sel = {1'b0, eau_pkg::SP_IDX};
      gw_word = 1'b1;
      gw_data = pop_sp_q + eau_pkg::STEP_WORD;
    end else if (accept && legal && uw_en) begin
      gw_en = 1'b1;
      gw_sel = uw_sel;
      gw_word = 1'b1;
      gw_data = uw_data;
    end
  end

  // sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= eau_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        eau_pkg::ST_IDLE: if (accept && legal && need_bus) begin
          state_q <= eau_pkg::ST_BUS;
        end
        eau_pkg::ST_BUS: if (mem_ack) begin
          state_q <= eau_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // completion pulse and fault
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= (accept && !(legal && need_bus)) || (state_q == eau_pkg::ST_BUS && mem_ack);
      illegal_q <= accept && !legal;
    end
  end

  // result registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_q <= eau_pkg::RST_WORD;
      operand_q <= eau_pkg::RST_WORD;
      target_q <= eau_pkg::RST_WORD;
      bit_num_q <= 3'h0;
      pop_sp_q <= eau_pkg::RST_WORD;
      pop_q <= 1'b0;
    end else if (accept && legal) begin
      ea_q <= ea_raw;
      operand_q <= operand_d;
      target_q <= target_d;
      bit_num_q <= bit_num_d;
      pop_sp_q <= rd2_w;
      pop_q <= (req_cls == eau_pkg::CL_FLAG_POP);
    end else if (state_q == eau_pkg::ST_BUS && mem_ack && !pop_q && !mem_we_q) begin
      target_q <= mem_rdata & eau_pkg::EVEN_MASK;
    end
  end

  // restored flags take the upper byte only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= eau_pkg::RST_BYTE;
    end else if (pop_ack) begin
      flags_q <= mem_rdata[eau_pkg::FLAG_HI_LSB +: 8];
    end
  end

  // memory bus request, held until acknowledged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= eau_pkg::RST_WORD;
      mem_wdata_q <= eau_pkg::RST_WORD;
    end else if (accept && legal && need_bus) begin
      mem_req_q <= 1'b1;
      mem_we_q <= bus_we;
      mem_addr_q <= bus_addr;
      mem_wdata_q <= bus_wdata;
    end else if (mem_ack) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
    end
  end

  // checks
  chk_word_even: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(done_q) && $past(accept && legal && req_word) |-> ea_q[0] == 1'b0)
    else $error("word address is odd");
  chk_flag_copies: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req_q && mem_we_q |-> mem_wdata_q[15:8] == mem_wdata_q[7:0])
    else $error("pushed flag halves differ");
  chk_bad_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && req_cls == eau_pkg::CL_BRANCH && req_mode != eau_pkg::MD_PCREL
    |=> illegal_q && done_q)
    else $error("branch with wrong mode not refused");
  chk_arith_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && req_cls == eau_pkg::CL_ARITH && req_mode == eau_pkg::MD_IMM |=> illegal_q)
    else $error("arithmetic immediate not refused");
  chk_ind_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && legal && req_cls == eau_pkg::CL_MOVE && req_mode == eau_pkg::MD_IND && !req_word
    |=> ea_q == $past(reg_w))
    else $error("indirect address mismatch");
  chk_predec_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && legal && req_cls == eau_pkg::CL_MOVE && req_mode == eau_pkg::MD_PREDEC
    && req_word |=> ea_q == (($past(reg_w) - 16'h0002) & 16'hfffe))
    else $error("pre-decrement address wrong");
  chk_postinc_wb: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && legal && req_mode == eau_pkg::MD_POSTINC && !req_word
    && req_cls == eau_pkg::CL_MOVE |-> gw_en && gw_data == reg_w + 16'h0001)
    else $error("post-increment write-back wrong");
  chk_abs8_page: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && legal && req_mode == eau_pkg::MD_ABS8 |=> ea_q[15:8] == 8'hff)
    else $error("short absolute page wrong");
  chk_pcrel_target: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && req_cls == eau_pkg::CL_BRANCH && req_mode == eau_pkg::MD_PCREL
    |=> target_q == (($past(pc_in) + {{8{$past(ins_byte2[7])}}, $past(ins_byte2)})
        & 16'hfffe))
    else $error("relative target wrong");
  chk_memind_page: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(mem_req_q) && !mem_we_q && !pop_q |-> mem_addr_q[15:8] == 8'h00)
    else $error("indirect pointer outside zero page");
  chk_target_even: assert property (@(posedge core_clk) disable iff (!rst_n)
    done_q |-> target_q[0] == 1'b0)
    else $error("branch target is odd");

  cov_push: cover property (@(posedge core_clk) disable iff (!rst_n)
    accept && req_cls == eau_pkg::CL_FLAG_PUSH ##[1:8] done_q);
  cov_pop: cover property (@(posedge core_clk) disable iff (!rst_n) pop_ack);
  cov_memind: cover property (@(posedge core_clk) disable iff (!rst_n)
    accept && legal && req_mode == eau_pkg::MD_MEMIND ##[1:8] done_q);
  cov_illegal: cover property (@(posedge core_clk) disable iff (!rst_n) illegal_q);

endmodule : eau_unit

//--- tb/eau_mem_model.sv
// memory bus partner: word memory with a programmable acknowledge delay
// assumes the unit holds each request until mem_ack; idle read data is scrambled
`timescale 1ns/10ps
module eau_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mem_req_q,
  input wire logic mem_we_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [15:0] mem_wdata_q,
  input wire logic [3:0] ack_wait,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic [15:0] last_addr,
  output logic [15:0] wr_data
);
  logic [15:0] mem [0:255];
  logic [3:0] cnt_q;
  // ack after ack_wait waiting cycles; read data valid only with the ack
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt_q <= 4'h0;
      mem_rdata <= 16'h5a5a;
      last_addr <= 16'h0000;
      wr_data <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_q && !mem_ack) begin
        if (cnt_q == ack_wait) begin
          mem_ack <= 1'b1;
          cnt_q <= 4'h0;
          last_addr <= mem_addr_q;
          if (mem_we_q) begin
            mem[mem_addr_q[8:1]] <= mem_wdata_q;
            wr_data <= mem_wdata_q;
          end else begin
            mem_rdata <= mem[mem_addr_q[8:1]];
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : eau_mem_model

//--- tb/eau_unit_test.sv
// testbench for the effective address unit, one task per scenario
// assumes the memory partner model on the bus side
`timescale 1ns/10ps
module eau_unit_test;
  logic core_clk, rst_n, req_valid, req_word, req_bit_from_reg, req_bit_in_b4;
  logic ext_wr_en, ext_wr_word, mem_ack, req_ready, done_q, illegal_q, mem_req_q, mem_we_q;
  logic ext_wr_ready, ill, xr;
  eau_pkg::eau_cls_t req_cls;
  eau_pkg::eau_mode_t req_mode;
  logic [3:0] req_reg_sel, req_bit_reg_sel, ext_wr_sel, ack_wait;
  logic [7:0] ins_byte2, ins_byte3, ins_byte4, flags_in, flags_q;
  logic [15:0] pc_in, ext_wr_data, ea_q, operand_q, target_q, mem_addr_q, mem_wdata_q;
  logic [15:0] mem_rdata, last_addr, wr_data;
  logic [2:0] bit_num_q;
  int miscompares = 0;
  int checks = 0;

  eau_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_cls(req_cls), .req_mode(req_mode), .req_word(req_word),
    .req_reg_sel(req_reg_sel), .req_bit_from_reg(req_bit_from_reg),
    .req_bit_reg_sel(req_bit_reg_sel), .req_bit_in_b4(req_bit_in_b4),
    .ins_byte2(ins_byte2), .ins_byte3(ins_byte3), .ins_byte4(ins_byte4), .pc_in(pc_in),
    .flags_in(flags_in), .done_q(done_q), .illegal_q(illegal_q), .ea_q(ea_q),
    .operand_q(operand_q), .target_q(target_q), .bit_num_q(bit_num_q), .flags_q(flags_q),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ext_wr_en(ext_wr_en), .ext_wr_ready(ext_wr_ready), .ext_wr_sel(ext_wr_sel),
    .ext_wr_word(ext_wr_word), .ext_wr_data(ext_wr_data));

  eau_mem_model mem_u (.core_clk(core_clk), .rst_n(rst_n), .mem_req_q(mem_req_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .ack_wait(ack_wait), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .last_addr(last_addr), .wr_data(wr_data));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // register write through the datapath port
  task automatic wr(input logic [3:0] s, input logic w, input logic [15:0] d);
    ext_wr_sel = s;
    ext_wr_word = w;
    ext_wr_data = d;
    ext_wr_en = 1'b1;
    @(posedge core_clk);
    #1 ext_wr_en = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : wr

  // one request, wait for done, keep the illegal flag
  task automatic rq(input eau_pkg::eau_cls_t c, input eau_pkg::eau_mode_t m,
                    input logic w, input logic [3:0] s = 4'h0,
                    input logic [7:0] b2 = 8'h00, input logic [15:0] b34 = 16'h0000);
    int n;
    req_cls = c;
    req_mode = m;
    req_word = w;
    req_reg_sel = s;
    ins_byte2 = b2;
    {ins_byte3, ins_byte4} = b34;
    req_valid = 1'b1;
    #1 xr = ext_wr_ready;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (done_q !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("done", done_q, 1'b1);
    ill = illegal_q;
    @(posedge core_clk);
    #1;
  endtask : rq

  task automatic t_regs;
    wr(4'h1, 1'b1, 16'h1234);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h1);
    chk("op_word", operand_q, 16'h1234);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_REG, 1'b0, 4'h9);
    chk("op_low", operand_q[7:0], 8'h34);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_REG, 1'b0, 4'h1);
    chk("op_high", operand_q[7:0], 8'h12);
    wr(4'h9, 1'b0, 16'h00cd);
    rq(eau_pkg::CL_MULDIV, eau_pkg::MD_REG, 1'b1, 4'h1);
    chk("op_merge", operand_q, 16'h12cd);
    rq(eau_pkg::CL_WORD_ARITH, eau_pkg::MD_REG, 1'b0, 4'h1);
    chk("op_warith", operand_q, 16'h12cd);
    rq(eau_pkg::CL_ADDR_ADJ, eau_pkg::MD_REG, 1'b1, 4'h1);
    chk("imp_two", operand_q, 16'h0002);
    rq(eau_pkg::CL_ADDR_ADJ, eau_pkg::MD_REG, 1'b0, 4'h1);
    chk("imp_one", operand_q, 16'h0001);
  endtask : t_regs

  task automatic t_ind;
    wr(4'h2, 1'b1, 16'h4567);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_IND, 1'b1, 4'h2);
    chk("ea_ind_w", ea_q, 16'h4566);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_IND, 1'b0, 4'h2);
    chk("ea_ind_b", ea_q, 16'h4567);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_DISP, 1'b0, 4'h2, 8'h00, 16'hbcaa);
    chk("ea_disp", ea_q, 16'h0211);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_DISP, 1'b0, 4'h2);
    chk("ill_disp", ill, 1'b1);
    chk("ea_kept", ea_q, 16'h0211);
  endtask : t_ind

  task automatic t_step;
    wr(4'h3, 1'b1, 16'hffff);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_POSTINC, 1'b0, 4'h3);
    chk("ea_post", ea_q, 16'hffff);
    chk("xw_busy", xr, 1'b0);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h3);
    chk("reg_post", operand_q, 16'h0000);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_PREDEC, 1'b1, 4'h3);
    chk("ea_pre", ea_q, 16'hfffe);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h3);
    chk("reg_pre", operand_q, 16'hfffe);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_POSTINC, 1'b1, 4'h3);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h3);
    chk("reg_post_w", operand_q, 16'h0000);
  endtask : t_step

  task automatic t_abs_imm;
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_ABS8, 1'b0, 4'h0, 8'h3c);
    chk("ea_abs8", ea_q, 16'hff3c);
    rq(eau_pkg::CL_JUMP, eau_pkg::MD_ABS8, 1'b0);
    chk("ill_abs8", ill, 1'b1);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_ABS16, 1'b1, 4'h0, 8'h00, 16'h8001);
    chk("ea_abs16", ea_q, 16'h8000);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_ABS16, 1'b0);
    chk("ill_abs16", ill, 1'b1);
    rq(eau_pkg::CL_ARITH_IMM, eau_pkg::MD_IMM, 1'b0, 4'h0, 8'h9e);
    chk("op_imm8", operand_q[7:0], 8'h9e);
    chk("ok_imm8", ill, 1'b0);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_IMM, 1'b0);
    chk("ill_imm", ill, 1'b1);
    rq(eau_pkg::CL_ARITH, eau_pkg::MD_IND, 1'b0);
    chk("ill_ind", ill, 1'b1);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_IMM, 1'b1, 4'h0, 8'h00, 16'hbeef);
    chk("op_imm16", operand_q, 16'hbeef);
  endtask : t_abs_imm

  task automatic t_bit;
    wr(4'h4, 1'b1, 16'h8026);
    rq(eau_pkg::CL_BIT, eau_pkg::MD_REG, 1'b0, 4'h4, 8'h50);
    chk("bit_b2", bit_num_q, 3'h5);
    req_bit_in_b4 = 1'b1;
    rq(eau_pkg::CL_BIT, eau_pkg::MD_IND, 1'b0, 4'h4, 8'h50, 16'h0070);
    chk("bit_b4", bit_num_q, 3'h7);
    req_bit_in_b4 = 1'b0;
    req_bit_from_reg = 1'b1;
    rq(eau_pkg::CL_BIT_REG, eau_pkg::MD_REG, 1'b0, 4'h4);
    chk("bit_reg", bit_num_q, 3'h6);
    req_bit_from_reg = 1'b0;
    rq(eau_pkg::CL_BIT, eau_pkg::MD_DISP, 1'b0, 4'h4);
    chk("ill_bit", ill, 1'b1);
  endtask : t_bit

  task automatic t_branch;
    pc_in = 16'h1001;
    rq(eau_pkg::CL_BRANCH, eau_pkg::MD_PCREL, 1'b0, 4'h0, 8'h80);
    chk("tgt_back", target_q, 16'h0f80);
    pc_in = 16'hfff0;
    rq(eau_pkg::CL_BRANCH, eau_pkg::MD_PCREL, 1'b0, 4'h0, 8'h20);
    chk("tgt_wrap", target_q, 16'h0010);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_PCREL, 1'b0);
    chk("ill_pcrel", ill, 1'b1);
    rq(eau_pkg::CL_BRANCH, eau_pkg::MD_IND, 1'b0);
    chk("ill_branch", ill, 1'b1);
    mem_u.mem[8'h10] = 16'h1235;
    ack_wait = 4'h3;
    rq(eau_pkg::CL_JUMP, eau_pkg::MD_MEMIND, 1'b0, 4'h0, 8'h21);
    chk("mi_addr", last_addr, 16'h0020);
    chk("mi_tgt", target_q, 16'h1234);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_MEMIND, 1'b0);
    chk("ill_memind", ill, 1'b1);
  endtask : t_branch

  // flag byte through the stack, word accesses only
  task automatic t_flags;
    wr(4'h7, 1'b1, 16'h0101);
    ack_wait = 4'h0;
    flags_in = 8'ha5;
    rq(eau_pkg::CL_FLAG_PUSH, eau_pkg::MD_REG, 1'b1);
    chk("push_addr", last_addr, 16'h00fe);
    chk("push_data", wr_data, 16'ha5a5);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h7);
    chk("sp_push", operand_q, 16'h00ff);
    mem_u.mem[8'h7f] = 16'h3cc3;
    ack_wait = 4'h2;
    rq(eau_pkg::CL_FLAG_POP, eau_pkg::MD_REG, 1'b1);
    chk("pop_flags", flags_q, 8'h3c);
    rq(eau_pkg::CL_MOVE, eau_pkg::MD_REG, 1'b1, 4'h7);
    chk("sp_pop", operand_q, 16'h0101);
  endtask : t_flags

  initial begin
    #20000;
    miscompares++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    {req_valid, req_word, req_bit_from_reg, req_bit_in_b4, ext_wr_en, ext_wr_word} = '0;
    req_cls = eau_pkg::CL_MOVE;
    req_mode = eau_pkg::MD_REG;
    {req_reg_sel, req_bit_reg_sel, ext_wr_sel, ack_wait} = '0;
    req_bit_reg_sel = 4'hc;
    {ins_byte2, ins_byte3, ins_byte4, flags_in, pc_in, ext_wr_data} = '0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("ready_rst", req_ready, 1'b1);
    chk("done_rst", done_q, 1'b0);
    t_regs();
    t_ind();
    t_step();
    t_abs_imm();
    t_bit();
    t_branch();
    t_flags();
    test_done();
  end
endmodule : eau_unit_test
